// ==== logic/mcp_pin_ctrl.sv ====
module mcp_pin_ctrl #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned CNT_W = 22,
  parameter int unsigned PULSE_CYC = 32'(mcp_pkg::PULSE_CYCLES)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic intrusionIn,
  output mcp_pkg::mcp_od_type intrusionPin,
  input wire logic intReqIn,
  output mcp_pkg::mcp_od_type intPin,
  input wire logic resetPinIn,
  output mcp_pkg::mcp_od_type resetPin,
  output logic coreResetOut,
  input wire logic treeSelectIn,
  input wire logic treeChainIn,
  input wire logic addrLowIn,
  input wire logic addrHighIn,
  output mcp_pkg::mcp_od_type addrLowPin,
  output logic analogOutEnable,
  output logic [6:0] serialAddr,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaPullLow,
  output mcp_pkg::mcp_od_type sdaPin,
  output logic sclSync,
  output logic sdaSync,
  output logic [6:0] linkAddr,
  output logic linkAddrValid
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
    $error("address width cannot hold the register map");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] pinMeta_ff;
  logic [5:0] pinSync_ff;
  logic [5:0] pinRaw;

  assign pinRaw = {addrHighIn, addrLowIn, treeChainIn, treeSelectIn,
                   resetPinIn, intrusionIn};

  always_ff @(posedge clk) begin
    if (reset) begin
      pinMeta_ff <= mcp_pkg::PIN_SYNC_RST;
      pinSync_ff <= mcp_pkg::PIN_SYNC_RST;
    end else begin
      pinMeta_ff <= pinRaw;
      pinSync_ff <= pinMeta_ff;
    end
  end

  logic intrLevel;
  logic rstPinLevel;
  logic treeMode;
  logic chainLevel;
  logic aLowLevel;
  logic aHighLevel;

  assign intrLevel = pinSync_ff[0];
  assign rstPinLevel = pinSync_ff[1];
  assign treeMode = pinSync_ff[2];
  assign chainLevel = pinSync_ff[3];
  assign aLowLevel = pinSync_ff[4];
  assign aHighLevel = pinSync_ff[5];

  // ----------------------------------------
  // reset pin as input
  // ----------------------------------------
  logic rstBusy;
  logic clrBusy;
  logic [2:0] holdoff_ff;
  logic pinResetHit;
  logic regReset;
  logic coreReset_ff;

  // own pulse reads back low, so mask it and the sync lag after it
  always_ff @(posedge clk) begin
    if (reset) begin
      holdoff_ff <= 3'h0;
    end else if (rstBusy) begin
      holdoff_ff <= mcp_pkg::PIN_HOLDOFF;
    end else if (holdoff_ff != 3'h0) begin
      holdoff_ff <= holdoff_ff - 3'h1;
    end
  end

  assign pinResetHit = !rstPinLevel && !rstBusy && holdoff_ff == 3'h0;
  assign regReset = reset || pinResetHit;

  always_ff @(posedge clk) begin
    if (reset) begin
      coreReset_ff <= 1'h1;
    end else begin
      coreReset_ff <= pinResetHit;
    end
  end

  assign coreResetOut = coreReset_ff;

  // ----------------------------------------
  // serial address capture
  // ----------------------------------------
  logic [1:0] capCnt_ff;
  logic addrDone_ff;
  logic [6:0] addr_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      capCnt_ff <= 2'h0;
      addrDone_ff <= 1'h0;
      addr_ff <= {mcp_pkg::ADDR_FIXED, 2'h0};
    end else if (!addrDone_ff) begin
      if (capCnt_ff == mcp_pkg::CAPTURE_WAIT) begin
        addrDone_ff <= 1'h1;
        addr_ff <= {mcp_pkg::ADDR_FIXED, aHighLevel, aLowLevel};
      end else begin
        capCnt_ff <= capCnt_ff + 2'h1;
      end
    end
  end

  assign serialAddr = addr_ff;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  function automatic mcp_pkg::mcp_reg_type decodeReg(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    decodeReg = mcp_pkg::REG_NONE;
    if (a[1:0] == 2'h0 && (a >> 10) == '0) begin
      case (idx)
        mcp_pkg::IDX_CFG: decodeReg = mcp_pkg::REG_CFG;
        mcp_pkg::IDX_RSTCTL: decodeReg = mcp_pkg::REG_RSTCTL;
        mcp_pkg::IDX_CICLR: decodeReg = mcp_pkg::REG_CICLR;
        mcp_pkg::IDX_STAT: decodeReg = mcp_pkg::REG_STAT;
        default: decodeReg = mcp_pkg::REG_NONE;
      endcase
    end
  endfunction

  mcp_pkg::mcp_reg_type regSel;
  logic access;
  logic wrEn;
  logic rdSetup;

  assign regSel = decodeReg(paddr);
  assign access = psel && penable;
  assign pready = access;
  assign pslverr = access && regSel == mcp_pkg::REG_NONE;
  assign wrEn = access && pwrite;
  assign rdSetup = psel && !penable && !pwrite;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [7:0] cfg_ff;
  logic [7:0] rstCtl_ff;
  logic rstGo;
  logic clrGo;
  logic [7:0] cfgKeepMask;

  assign cfgKeepMask = ~((8'h01 << mcp_pkg::CFG_RST_GO_BIT)
                         | (8'h01 << mcp_pkg::CFG_CICLR_BIT));

  always_ff @(posedge clk) begin
    if (regReset) begin
      cfg_ff <= mcp_pkg::CFG_RST;
    end else if (wrEn && regSel == mcp_pkg::REG_CFG) begin
      cfg_ff <= pwdata[7:0] & cfgKeepMask;
    end
  end

  always_ff @(posedge clk) begin
    if (regReset) begin
      rstCtl_ff <= mcp_pkg::RSTCTL_RST;
    end else if (wrEn && regSel == mcp_pkg::REG_RSTCTL) begin
      rstCtl_ff <= pwdata[7:0];
    end
  end

  assign rstGo = wrEn && regSel == mcp_pkg::REG_CFG
                 && pwdata[mcp_pkg::CFG_RST_GO_BIT]
                 && rstCtl_ff[mcp_pkg::RSTCTL_EN_BIT];
  assign clrGo = wrEn && ((regSel == mcp_pkg::REG_CFG && pwdata[mcp_pkg::CFG_CICLR_BIT])
                 || (regSel == mcp_pkg::REG_CICLR
                 && pwdata[mcp_pkg::CICLR_GO_BIT]));

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] rdValue;
  logic [31:0] prdata_ff;

  always_comb begin
    rdValue = 32'h0000_0000;
    case (regSel)
      mcp_pkg::REG_CFG: begin
        rdValue[7:0] = cfg_ff;
        rdValue[mcp_pkg::CFG_RST_GO_BIT] = rstBusy;
        rdValue[mcp_pkg::CFG_CICLR_BIT] = clrBusy;
      end
      mcp_pkg::REG_RSTCTL: begin
        rdValue[7:0] = rstCtl_ff;
      end
      mcp_pkg::REG_CICLR: begin
        rdValue[mcp_pkg::CICLR_GO_BIT] = clrBusy;
      end
      mcp_pkg::REG_STAT: begin
        rdValue[mcp_pkg::STAT_INTR_BIT] = intrLevel;
        rdValue[mcp_pkg::STAT_CLR_BIT] = clrBusy;
        rdValue[mcp_pkg::STAT_RST_BIT] = rstBusy;
        rdValue[mcp_pkg::STAT_TREE_BIT] = treeMode;
        rdValue[mcp_pkg::STAT_INT_BIT] = intPin.oe;
        rdValue[mcp_pkg::STAT_ADDR_LSB +: 7] = addr_ff;
        rdValue[mcp_pkg::STAT_CAP_BIT] = addrDone_ff;
      end
      default: rdValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rdSetup) begin
      prdata_ff <= rdValue;
    end
  end

  assign prdata = prdata_ff;

  // ----------------------------------------
  // pulse timers
  // ----------------------------------------
  mcp_pulse_timer #(
    .CNT_W(CNT_W),
    .CYC(PULSE_CYC)
  ) u_clr_timer (
    .clk(clk),
    .reset(reset),
    .start(clrGo),
    .busy(clrBusy)
  );

  mcp_pulse_timer #(
    .CNT_W(CNT_W),
    .CYC(PULSE_CYC)
  ) u_rst_timer (
    .clk(clk),
    .reset(reset),
    .start(rstGo),
    .busy(rstBusy)
  );

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  logic intOe_ff;
  logic treeOe_ff;
  logic chainOut_ff;

  always_ff @(posedge clk) begin
    if (regReset) begin
      intOe_ff <= 1'h0;
    end else begin
      intOe_ff <= cfg_ff[mcp_pkg::CFG_INT_EN_BIT] && intReqIn;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      treeOe_ff <= 1'h0;
      chainOut_ff <= 1'h0;
    end else begin
      treeOe_ff <= treeMode;
      chainOut_ff <= chainLevel;
    end
  end

  assign intrusionPin = '{out: 1'h0, oe: clrBusy};
  assign intPin = '{out: 1'h0, oe: intOe_ff};
  assign resetPin = '{out: 1'h0, oe: rstBusy};
  assign addrLowPin = '{out: chainOut_ff, oe: treeOe_ff};
  assign analogOutEnable = !treeOe_ff;

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  logic linkRstMeta_ff;
  logic linkRst_ff;
  logic sclMeta_ff;
  logic sclSync_ff;
  logic sdaMeta_ff;
  logic sdaSync_ff;
  logic addrOkMeta_ff;
  logic addrOkSync_ff;
  logic [6:0] linkAddr_ff;
  logic linkValid_ff;
  logic sdaDrive_ff;

  always_ff @(posedge linkClk) begin
    linkRstMeta_ff <= reset;
    linkRst_ff <= linkRstMeta_ff;
  end

  always_ff @(posedge linkClk) begin
    if (linkRst_ff) begin
      sclMeta_ff <= 1'h1;
      sclSync_ff <= 1'h1;
      sdaMeta_ff <= 1'h1;
      sdaSync_ff <= 1'h1;
    end else begin
      sclMeta_ff <= sclIn;
      sclSync_ff <= sclMeta_ff;
      sdaMeta_ff <= sdaIn;
      sdaSync_ff <= sdaMeta_ff;
    end
  end

  // address is frozen once captured, so a level flag hands it over
  always_ff @(posedge linkClk) begin
    if (linkRst_ff) begin
      addrOkMeta_ff <= 1'h0;
      addrOkSync_ff <= 1'h0;
      linkAddr_ff <= 7'h00;
      linkValid_ff <= 1'h0;
    end else begin
      addrOkMeta_ff <= addrDone_ff;
      addrOkSync_ff <= addrOkMeta_ff;
      if (addrOkSync_ff && !linkValid_ff) begin
        linkAddr_ff <= addr_ff;
        linkValid_ff <= 1'h1;
      end
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst_ff) begin
      sdaDrive_ff <= 1'h0;
    end else begin
      sdaDrive_ff <= sdaPullLow;
    end
  end

  assign sclSync = sclSync_ff;
  assign sdaSync = sdaSync_ff;
  assign linkAddr = linkAddr_ff;
  assign linkAddrValid = linkValid_ff;
  assign sdaPin = '{out: 1'h0, oe: sdaDrive_ff};

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [31:0] clrLen_ff;
  logic [31:0] rstLen_ff;
  localparam int unsigned PULSE_LAST = PULSE_CYC - 1;

  always_ff @(posedge clk) begin
    clrLen_ff <= intrusionPin.oe ? clrLen_ff + 32'h0000_0001 : 32'h0000_0000;
    rstLen_ff <= resetPin.oe ? rstLen_ff + 32'h0000_0001 : 32'h0000_0000;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  intr_level_a: assert property (!$past(reset) && !$past(reset, 2) |->
    pinSync_ff[0] == $past(intrusionIn, 2)) else $error("intrusion level lost");
  clr_start_a: assert property (clrGo && !clrBusy |=> intrusionPin.oe)
    else $error("intrusion clear did not start");
  clr_width_a: assert property ($fell(intrusionPin.oe) && !$past(reset) |->
    $past(clrLen_ff) == PULSE_LAST) else $error("intrusion clear width wrong");
  int_gate_a: assert property (intPin.oe |->
    $past(cfg_ff[mcp_pkg::CFG_INT_EN_BIT]) && $past(intReqIn))
    else $error("interrupt driven while disabled");
  rst_width_a: assert property ($fell(resetPin.oe) && !$past(reset) |->
    $past(rstLen_ff) == PULSE_LAST) else $error("reset pulse width wrong");
  rst_enable_a: assert property ($rose(resetPin.oe) |->
    $past(rstCtl_ff[mcp_pkg::RSTCTL_EN_BIT]) && $past(wrEn))
    else $error("reset pulse without enable");
  pin_reset_a: assert property (pinResetHit |=>
    cfg_ff == mcp_pkg::CFG_RST && rstCtl_ff == mcp_pkg::RSTCTL_RST && coreResetOut)
    else $error("pin reset did not clear registers");
  tree_pins_a: assert property (!$past(reset) |->
    addrLowPin.oe == $past(treeMode) && analogOutEnable == !addrLowPin.oe)
    else $error("tree mode pins wrong");
  addr_fixed_a: assert property ($rose(addrDone_ff) |->
    serialAddr == {mcp_pkg::ADDR_FIXED, $past(aHighLevel), $past(aLowLevel)})
    else $error("serial address wrong");
  sda_od_a: assert property (@(posedge linkClk) disable iff (reset || linkRst_ff)
    sdaPin.out == 1'h0 && sdaPin.oe == $past(sdaPullLow))
    else $error("data pin not open drain");

  clr_seen_c: cover property ($fell(intrusionPin.oe));
  rst_seen_c: cover property ($fell(resetPin.oe));
  pin_reset_c: cover property (pinResetHit);
  tree_mode_c: cover property ($rose(addrLowPin.oe));

endmodule // mcp_pin_ctrl

// ==== logic/mcp_pkg.sv ====
package mcp_pkg;

  // ----------------------------------------
  // register indices, byte address is four times
  // ----------------------------------------
  localparam logic [7:0] IDX_CFG = 8'h40;
  localparam logic [7:0] IDX_RSTCTL = 8'h44;
  localparam logic [7:0] IDX_CICLR = 8'h46;
  localparam logic [7:0] IDX_STAT = 8'h4A;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_INT_EN_BIT = 1;
  localparam int CFG_RST_GO_BIT = 4;
  localparam int CFG_CICLR_BIT = 6;
  localparam int RSTCTL_EN_BIT = 7;
  localparam int CICLR_GO_BIT = 7;
  localparam int STAT_INTR_BIT = 0;
  localparam int STAT_CLR_BIT = 1;
  localparam int STAT_RST_BIT = 2;
  localparam int STAT_TREE_BIT = 3;
  localparam int STAT_INT_BIT = 4;
  localparam int STAT_ADDR_LSB = 8;
  localparam int STAT_CAP_BIT = 15;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RSTCTL_RST = 8'h00;
  localparam logic [5:0] PIN_SYNC_RST = 6'h02;
  localparam logic [4:0] ADDR_FIXED = 5'h0B;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint unsigned CLK_HZ = 64'h0000_0000_0773_5940;
  localparam longint unsigned PULSE_MS = 64'h0000_0000_0000_0014;
  localparam longint unsigned PULSE_CYCLES = (PULSE_MS * CLK_HZ + 999) / 1000;
  localparam logic [2:0] PIN_HOLDOFF = 3'h4;
  localparam logic [1:0] CAPTURE_WAIT = 2'h3;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic out;
    logic oe;
  } mcp_od_type;

  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_CFG = 3'h1,
    REG_RSTCTL = 3'h3,
    REG_CICLR = 3'h2,
    REG_STAT = 3'h6
  } mcp_reg_type;

endpackage

// ==== logic/mcp_pulse_timer.sv ====
module mcp_pulse_timer #(
  parameter int unsigned CNT_W = 22,
  parameter int unsigned CYC = 2500000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  output logic busy
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (CYC < 1 || CNT_W > 31 || CYC >= (32'h0000_0001 << CNT_W)) begin : g_bad
    $error("pulse length does not fit counter");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  // ----------------------------------------
  // self-ending down counter
  // ----------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CNT_W'(1);
    end else if (start) begin
      nxt_cnt = CNT_W'(CYC);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff <= '0;
      busy <= 1'h0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy <= (nxt_cnt != '0);
    end
  end

endmodule // mcp_pulse_timer

// ==== verif/mcp_link_model.sv ====
// ----------------------------------------
// serial host side of the link
// ----------------------------------------
module mcp_link_model (
  input wire logic linkClk,
  input wire logic reset,
  input wire logic go,
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn,
  output logic sdaPullLow,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hostSda;
  int bits;
  // wired-and with pull-up, device only pulls low
  assign sdaIn = hostSda & !sdaOe;
  initial begin
    sclIn = 1'b1;
    hostSda = 1'b1;
    sdaPullLow = 1'b0;
    busy = 1'b0;
    bits = 0;
  end
  // clock toggles only inside a frame, idles high
  always @(posedge linkClk) begin
    if (reset) begin
      busy <= 1'b0;
      sclIn <= 1'b1;
      hostSda <= 1'b1;
      sdaPullLow <= 1'b0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      bits <= 18;
    end else if (busy) begin
      sclIn <= !sclIn;
      if (sclIn) begin
        hostSda <= 1'($urandom);
        sdaPullLow <= 1'($urandom);
      end
      bits <= bits - 1;
      if (bits == 1) begin
        busy <= 1'b0;
        sclIn <= 1'b1;
        hostSda <= 1'b1;
        sdaPullLow <= 1'b0;
      end
    end
  end
endmodule // mcp_link_model

// ==== verif/tb.sv ====
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin badCount++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PC = 20;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic intrLatch, extRstLow, addrLowDrv, addrHighIn, intReqIn, treeSelectIn, treeChainIn;
  logic go, linkBusy, linkChk, sclIn, sdaIn, sdaPullLow, sclSync, sdaSync, coreResetOut;
  logic analogOutEnable, linkAddrValid, pullSeen, sclD1, sclD2, sdaD1, sdaD2;
  logic [6:0] serialAddr, linkAddr, expAddr;
  mcp_pkg::mcp_od_type intrusionPin, intPin, resetPin, addrLowPin, sdaPin;
  int badCount = 0;
  int nTests = 0;
  int mdl[int];
  // ----------------------------------------
  // pin wiring, intrusion and reset pins pull low, addrLowPin drives its out value
  // ----------------------------------------
  wire logic intrusionIn = intrLatch & !intrusionPin.oe;
  wire logic resetPinIn = !(resetPin.oe | extRstLow);
  wire logic addrLowIn = addrLowPin.oe ? addrLowPin.out : addrLowDrv;
  always #4 clk = !clk;
  initial begin
    #3;
    forever #24 linkClk = !linkClk;
  end
  // external latch cleared by the clear pulse
  always @(posedge clk) if (intrusionPin.oe === 1'b1) intrLatch <= 1'b0;
  mcp_pin_ctrl #(.PULSE_CYC(PC)) i_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .intrusionIn, .intrusionPin, .intReqIn, .intPin,
    .resetPinIn, .resetPin, .coreResetOut, .treeSelectIn, .treeChainIn, .addrLowIn,
    .addrHighIn, .addrLowPin, .analogOutEnable, .serialAddr, .linkClk, .sclIn, .sdaIn,
    .sdaPullLow, .sdaPin, .sclSync, .sdaSync, .linkAddr, .linkAddrValid);
  mcp_link_model i_link (.linkClk, .reset, .go, .sdaOe(sdaPin.oe), .sclIn, .sdaIn,
    .sdaPullLow, .busy(linkBusy));
  // ----------------------------------------
  // link side checks
  // ----------------------------------------
  always @(posedge linkClk) begin
    pullSeen <= sdaPullLow;
    sclD1 <= sclIn;
    sclD2 <= sclD1;
    sdaD1 <= sdaIn;
    sdaD2 <= sdaD1;
  end
  always @(negedge linkClk) begin
    if (linkChk) begin
      `CHK(sdaPin.oe, pullSeen)
      `CHK(sclSync, sclD2)
      `CHK(sdaSync, sdaD2)
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) badCount++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
    `CHK(e, 1'b0)
  endtask
  task automatic rd(input logic [7:0] idx);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, '0, r, e);
    `CHK(r, 32'(mdl[idx]))
    `CHK(e, 1'b0)
  endtask
  task automatic pulse_len(input logic isRst, input int exp);
    int c;
    c = 0;
    repeat (PC + 20) begin
      @(posedge clk);
      if ((isRst ? resetPin.oe : intrusionPin.oe) === 1'b1) c++;
    end
    `CHK(c, exp)
  endtask
  task automatic done(input string s);
    $display("test %s done at %0t", s, $time);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    badCount++;
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic e, saw;
    void'($urandom(78));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {intrLatch, extRstLow, intReqIn, treeSelectIn, treeChainIn, go, linkChk} = '0;
    addrLowDrv = 1'($urandom);
    addrHighIn = 1'($urandom);
    expAddr = {5'b01011, addrHighIn, addrLowDrv};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    mdl[mcp_pkg::IDX_CFG] = 0;
    mdl[mcp_pkg::IDX_RSTCTL] = 0;
    mdl[mcp_pkg::IDX_CICLR] = 0;
    mdl[mcp_pkg::IDX_STAT] = 32'h8000 | (int'(expAddr) << 8);
    repeat (8) @(posedge clk);
    `CHK(serialAddr, expAddr)
    rd(mcp_pkg::IDX_CFG);
    rd(mcp_pkg::IDX_RSTCTL);
    rd(mcp_pkg::IDX_STAT);
    `CHK(intPin.oe, 1'b0)
    apb(1'b0, 8'h20, '0, r, e);
    `CHK({e, r}, 33'h0_0000_0000 | 33'h1_0000_0000)
    wr(mcp_pkg::IDX_STAT, 32'h0000_00FF);
    rd(mcp_pkg::IDX_STAT);
    done("reset values");
    intrLatch <= 1'b1;
    repeat (6) @(posedge clk);
    mdl[mcp_pkg::IDX_STAT] |= 1;
    rd(mcp_pkg::IDX_STAT);
    wr(mcp_pkg::IDX_CFG, 32'h0000_0040);
    pulse_len(1'b0, PC);
    `CHK(intrusionPin.out, 1'b0)
    mdl[mcp_pkg::IDX_STAT] &= ~1;
    rd(mcp_pkg::IDX_STAT);
    rd(mcp_pkg::IDX_CFG);
    intrLatch <= 1'b1;
    wr(mcp_pkg::IDX_CICLR, 32'h0000_0080);
    pulse_len(1'b0, PC);
    rd(mcp_pkg::IDX_CICLR);
    done("intrusion");
    mdl[mcp_pkg::IDX_RSTCTL] = $urandom & 32'h0000_007F;
    wr(mcp_pkg::IDX_RSTCTL, 32'(mdl[mcp_pkg::IDX_RSTCTL]));
    rd(mcp_pkg::IDX_RSTCTL);
    wr(mcp_pkg::IDX_CFG, 32'h0000_0010);
    pulse_len(1'b1, 0);
    mdl[mcp_pkg::IDX_RSTCTL] = ($urandom & 32'h0000_00FF) | 32'h0000_0080;
    wr(mcp_pkg::IDX_RSTCTL, 32'(mdl[mcp_pkg::IDX_RSTCTL]));
    wr(mcp_pkg::IDX_CFG, 32'h0000_0010);
    pulse_len(1'b1, PC);
    `CHK(resetPin.out, 1'b0)
    rd(mcp_pkg::IDX_CFG);
    done("reset pulse");
    intReqIn <= 1'b1;
    for (int en = 1; en >= 0; en--) begin
      mdl[mcp_pkg::IDX_CFG] = en * 2;
      wr(mcp_pkg::IDX_CFG, 32'(mdl[mcp_pkg::IDX_CFG]));
      repeat (3) @(posedge clk);
      `CHK(intPin.oe, 1'(en))
      `CHK(intPin.out, 1'b0)
    end
    done("interrupt pin");
    mdl[mcp_pkg::IDX_CFG] = 2;
    wr(mcp_pkg::IDX_CFG, 32'h0000_0002);
    saw = 1'b0;
    extRstLow <= 1'b1;
    repeat (6) begin
      @(posedge clk);
      if (coreResetOut === 1'b1) saw = 1'b1;
    end
    extRstLow <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(saw, 1'b1)
    mdl[mcp_pkg::IDX_CFG] = 0;
    mdl[mcp_pkg::IDX_RSTCTL] = 0;
    rd(mcp_pkg::IDX_CFG);
    rd(mcp_pkg::IDX_RSTCTL);
    `CHK(intPin.oe, 1'b0)
    `CHK(serialAddr, expAddr)
    done("pin reset");
    treeSelectIn <= 1'b1;
    repeat (4) begin
      treeChainIn <= 1'($urandom);
      repeat (6) @(posedge clk);
      `CHK(addrLowPin.oe, 1'b1)
      `CHK(addrLowPin.out, treeChainIn)
      `CHK(analogOutEnable, 1'b0)
    end
    treeSelectIn <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({addrLowPin.oe, analogOutEnable}, 2'b01)
    done("tree test");
    `CHK({linkAddrValid, linkAddr}, {1'b1, expAddr})
    linkChk <= 1'b1;
    repeat (2) begin
      go <= 1'b1;
      repeat (4) @(posedge linkClk);
      go <= 1'b0;
      repeat (30) @(posedge linkClk);
      `CHK(linkBusy, 1'b0)
    end
    `CHK(sdaPin.out, 1'b0)
    linkChk <= 1'b0;
    done("link");
    report_and_stop();
  end
endmodule // tb
